// *** shared/adc_port_consts.vh ***
`ifndef ADC_PORT_CONSTS_VH
`define ADC_PORT_CONSTS_VH
// result width and serial burst length
`define RESULT_BITS         16
`define BURST_PULSES        5'h10
// internal data clock: half period in ref_clk cycles
`define INT_CLK_HALF        8'h04
// conversion time in ns, and cycles derived at 10 ns per cycle
`define CONV_TIME_NS        4000
`define CLK_PERIOD_NS       10
`define CONV_CYCLES         (`CONV_TIME_NS / `CLK_PERIOD_NS)
// least convert low pulse in ns, rounded up to cycles
`define CONV_LOW_NS         40
`define CONV_LOW_CYCLES     ((`CONV_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// straight binary flips the msb of the two's complement code
`define FMT_MSB             15
`endif

// *** rtl/result_fifo.v ***
// small synchronous fifo holding raw conversion results
module result_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            do_wr;
   wire            do_rd;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   // pointers and occupancy; storage has no reset as it is gated by count
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= rd_ptr + 1'b1;
         if (do_wr && !do_rd)
            count <= count + 1'b1;
         else if (do_rd && !do_wr)
            count <= count - 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (do_wr)
         mem[wr_ptr] <= in_data;
   end
endmodule

// *** rtl/adc_output_port.v ***
// Summary of operation
// [R1] internal clock mode: 16 data clock pulses per conversion, then clock low
// [R2] data clock driven when source select low, taken from host when high
// [R3] serial data coded per the output-format select level when the result landed
// [R4] external mode: after 16 bits, chain input passes while selected and reading
// [R5] internal mode: each bit stable across the rising edge of generated clock, changing on the falling edge
// [R6] internal mode: idle serial line holds chain input captured at conversion start
// [R7] external mode: chain input flows through shifter, delayed by clocking
// [R8] parallel byte: msbs when half-select low, lsbs when high
// [R9] chip select low plus read/convert falling starts a conversion
// [R10] selects ORed as active-low levels; either falling edge may start
// [R11] internal mode: start of conversion N sends result N-1 serially
// [R12] busy low from start until conversion done and outputs updated
// [R13] power-down refuses conversions and keeps the shift register
// [R14] host holds read/convert low 40 ns to 5 us
// [R15] selected byte valid at busy rise; host may toggle half-select
// [R16] convert commands while busy low are ignored
// [R17] host spaces convert commands at least 5 us apart
// [R18] internal serial mode: busy waits for conversion and all serial bits
// [R19] serial result shifted out msb first
// [R20] host may latch result on busy rising edge
// [R21] format select high gives straight binary, low two's complement
// [R22] external mode: shifting follows host-supplied data clock
// [R23] result register stable from busy rise to next completion, except shifting
`include "adc_port_consts.vh"
module adc_output_port #(
   parameter CONV_CYCLES = `CONV_CYCLES,
   parameter FIFO_DEPTH  = 16
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        chip_select_n,
   input  wire        read_convert,
   input  wire        half_select,
   input  wire        output_format_select,
   input  wire        clock_source_select,
   input  wire        power_down_in,
   input  wire        chain_in,
   input  wire        serial_shift_clock_in,
   output reg         serial_shift_clock_out,
   output wire        serial_shift_clock_oe,
   output reg         serial_result_out,
   output reg  [7:0]  parallel_data,
   output wire        parallel_oe,
   output wire        busy_n,
   input  wire        sample_valid,
   output wire        sample_ready,
   input  wire [15:0] sample_data
);
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_WAIT = 2'h2;

   // two-stage synchronisers for every pin input
   reg [1:0] cs_s;
   reg [1:0] rc_s;
   reg [1:0] hs_s;
   reg [1:0] fmt_s;
   reg [1:0] src_s;
   reg [1:0] pd_s;
   reg [1:0] tag_s;
   reg [1:0] sck_s;
   reg       conv_lvl_d;
   reg       sck_d;

   // chip select resets deasserted so no false command edge follows reset
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         cs_s <= 2'h3;
      else
         cs_s <= {cs_s[0], chip_select_n};
   end

   // read/convert resets high, its idle read level
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         rc_s <= 2'h3;
      else
         rc_s <= {rc_s[0], read_convert};
   end

   // byte select for the parallel port
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         hs_s <= 2'h0;
      else
         hs_s <= {hs_s[0], half_select};
   end

   // output code format, applied when a result lands
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         fmt_s <= 2'h0;
      else
         fmt_s <= {fmt_s[0], output_format_select};
   end

   // data clock source; the pin driver follows the synced copy
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         src_s <= 2'h0;
      else
         src_s <= {src_s[0], clock_source_select};
   end

   // power-down request
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         pd_s <= 2'h0;
      else
         pd_s <= {pd_s[0], power_down_in};
   end

   // daisy-chain input level
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         tag_s <= 2'h0;
      else
         tag_s <= {tag_s[0], chain_in};
   end

   // host data clock; resets low, its idle level, to avoid a false rise
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         sck_s <= 2'h0;
      else
         sck_s <= {sck_s[0], serial_shift_clock_in};
   end

   wire cs_n   = cs_s[1];
   wire rc     = rc_s[1];
   wire ext    = src_s[1];
   wire pd     = pd_s[1];
   wire tag    = tag_s[1];
   wire sck    = sck_s[1];
   // active-low selects ORed into one convert level
   wire conv_lvl   = ~(cs_n | rc); // [R10]
   wire conv_fall  = conv_lvl & ~conv_lvl_d; // [R9] [R10]

   // edge history of the combined command and the host clock
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_lvl_d <= 1'b0;
         sck_d      <= 1'b0;
      end else begin
         conv_lvl_d <= conv_lvl;
         sck_d      <= sck;
      end
   end
   wire sck_rise = sck & ~sck_d;

   // conversion engine and busy
   reg [1:0]  state;
   reg [15:0] conv_cnt;
   reg [15:0] result;
   reg        int_active;
   wire       fifo_valid;
   wire [15:0] fifo_data;
   wire       start_conv = conv_fall & (state == ST_IDLE) & ~pd; // [R13] [R16]
   wire       conv_done  = (state == ST_CONV) && (conv_cnt == CONV_CYCLES[15:0] - 16'h0001);
   assign busy_n = (state == ST_IDLE); // [R12]

   // raw sample popped at completion; an empty source yields the old value
   wire [15:0] raw_next = fifo_valid ? fifo_data : result;
   // straight binary flips the msb of the two's complement code
   wire [15:0] coded = fmt_s[1] ? (raw_next ^ (16'h0001 << `FMT_MSB)) : raw_next; // [R3] [R21]

   // output shift register and bit counter
   reg [15:0] shreg;
   reg [4:0]  bits_out;
   reg        idle_tag;
   reg [7:0]  div_cnt;
   reg [4:0]  pulses;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state    <= ST_IDLE;
         conv_cnt <= 16'h0000;
         result   <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               conv_cnt <= 16'h0000;
               if (start_conv)
                  state <= ST_CONV; // [R9]
            end
            ST_CONV: begin
               conv_cnt <= conv_cnt + 16'h0001;
               if (conv_done) begin
                  result <= coded; // [R23]
                  state  <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // serial burst must also be finished before busy rises
               if (!int_active)
                  state <= ST_IDLE; // [R18]
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign sample_ready = conv_done; // pop one sample per conversion

   result_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH),
      .AW    (4)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (sample_valid),
      .in_ready  (),
      .in_data   (sample_data),
      .out_valid (fifo_valid),
      .out_ready (conv_done),
      .out_data  (fifo_data)
   );

   // internal clock divider: one enable per half period of the data clock
   wire half_tick = int_active && (div_cnt == `INT_CLK_HALF - 8'h01);
   assign serial_shift_clock_oe = ~ext; // [R2]

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         int_active             <= 1'b0;
         div_cnt                <= 8'h00;
         pulses                 <= 5'h00;
         serial_shift_clock_out <= 1'b0;
         shreg                  <= 16'h0000;
         bits_out               <= 5'h00;
         idle_tag               <= 1'b0;
         serial_result_out      <= 1'b0;
      end else begin
         if (start_conv) begin
            // same edge launches the previous result serially
            idle_tag <= tag; // [R6]
            shreg    <= result; // [R11]
            bits_out <= 5'h00;
            if (!ext) begin
               int_active             <= 1'b1; // [R1] [R11]
               div_cnt                <= 8'h00;
               pulses                 <= 5'h00;
               serial_shift_clock_out <= 1'b0;
               serial_result_out      <= result[15]; // [R19]
            end
         end else if (conv_done && ext) begin
            // external mode reloads with the fresh result when it lands
            shreg    <= coded;
            bits_out <= 5'h00;
         end else if (int_active) begin
            div_cnt <= half_tick ? 8'h00 : div_cnt + 8'h01;
            if (half_tick) begin
               serial_shift_clock_out <= ~serial_shift_clock_out;
               // bits change only on the falling edge, stable across the high phase
               if (serial_shift_clock_out) begin
                  pulses <= pulses + 5'h01;
                  shreg  <= {shreg[14:0], 1'b0};
                  if (pulses == `BURST_PULSES - 5'h01) begin
                     int_active        <= 1'b0; // [R1]
                     serial_result_out <= idle_tag; // [R6]
                  end else begin
                     serial_result_out <= shreg[14]; // [R5] [R19]
                  end
               end
            end
         end else if (ext) begin
            // host clock moves the shifter, chain data trailing the result
            if (sck_rise && !cs_n && rc) begin // [R22]
               shreg <= {shreg[14:0], tag}; // [R7]
               if (bits_out != `BURST_PULSES)
                  bits_out <= bits_out + 5'h01;
            end
            if (bits_out == `BURST_PULSES && !cs_n && rc)
               serial_result_out <= tag; // [R4]
            else
               serial_result_out <= shreg[15]; // [R19]
         end
      end
   end

   // parallel byte from the settled result, not the shifting copy
   assign parallel_oe = ~cs_n & rc;
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         parallel_data <= 8'h00;
      else
         parallel_data <= hs_s[1] ? result[7:0] : result[15:8]; // [R8] [R15]
   end
endmodule

// *** sim/adc_port_assertions.sv ***
module adc_port_checker #(
   parameter CONV_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic read_convert,
   input wire logic clock_source_select,
   input wire logic power_down_in,
   input wire logic serial_shift_clock_out,
   input wire logic serial_shift_clock_oe,
   input wire logic serial_result_out,
   input wire logic parallel_oe,
   input wire logic busy_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] low_cnt;
   logic [4:0] pulses;
   // busy length and clock pulses, cleared while idle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst || busy_n) begin
         low_cnt <= 10'h000;
         pulses  <= 5'h00;
      end else begin
         low_cnt <= low_cnt + 10'h001;
         if ($rose(serial_shift_clock_out)) pulses <= pulses + 5'h01;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // the enable follows the pins through the two-flop synchronisers
   AST_PAR_OE: assert property (parallel_oe == (($past(chip_select_n, 2) == 1'b0) && $past(read_convert, 2)))
      else $error("parallel enable wrong");
   AST_OE: assert property ($stable(clock_source_select)[*4] |-> serial_shift_clock_oe == !clock_source_select)
      else $error("clock enable wrong");
   AST_START: assert property ($rose(!chip_select_n && !read_convert) && busy_n && !power_down_in
      |-> ##[2:4] !busy_n) else $error("convert not taken");
   AST_PD: assert property (power_down_in[*4] ##0 busy_n |=> busy_n)
      else $error("conversion in power-down");
   AST_BUSY_MIN: assert property ($rose(busy_n) |-> low_cnt >= CONV_CYCLES)
      else $error("busy too short");
   AST_BURST: assert property ($rose(busy_n) && serial_shift_clock_oe |-> pulses == 5'h10)
      else $error("burst count wrong");
   AST_CLK_IDLE: assert property (busy_n && serial_shift_clock_oe |-> !serial_shift_clock_out)
      else $error("clock not low when idle");
   AST_BIT_STABLE: assert property ($rose(serial_shift_clock_out) && !$past(busy_n, 2)
      |-> $stable(serial_result_out)) else $error("bit moved at clock rise");
   cover property ($rose(busy_n) && serial_shift_clock_oe);
   cover property ($rose(busy_n) && !serial_shift_clock_oe);
   cover property (power_down_in && $fell(read_convert));
endmodule
bind adc_output_port adc_port_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (.ref_clk, .rst, .chip_select_n,
   .read_convert, .clock_source_select, .power_down_in, .serial_shift_clock_out, .serial_shift_clock_oe,
   .serial_result_out, .parallel_oe, .busy_n);

// *** sim/sample_source.sv ***
module sample_source (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        sample_ready,
   output logic             sample_valid,
   output logic [15:0]      sample_data,
   output logic [3:0]       pops
);
   timeunit 1ns;
   timeprecision 1ns;
   // raw codes in order; one word offered after reset and one after each completion,
   // so the fifo holds exactly the next sample and never fills with copies
   logic [15:0] codes [0:3] = '{16'h1234, 16'hA5C3, 16'h7F01, 16'h3C5A};
   logic        primed;
   assign sample_data  = codes[pops[1:0]];
   // one word taken per completion pulse, the next one pushed a cycle later
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pops         <= 4'h0;
         sample_valid <= 1'b0;
         primed       <= 1'b0;
      end else begin
         primed       <= 1'b1;
         sample_valid <= !primed || sample_ready;
         if (sample_ready) pops <= pops + 4'h1;
      end
   end
endmodule

// *** sim/sar_adc_conversion_output_port_bench.sv ***
module sar_adc_conversion_output_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk, rst, chip_select_n, read_convert, half_select, output_format_select, prev_clk;
   logic        clock_source_select, power_down_in, chain_in, serial_shift_clock_in, serial_shift_clock_out;
   logic        serial_shift_clock_oe, serial_result_out, parallel_oe, busy_n, sample_valid, sample_ready;
   logic [15:0] sample_data, word, bword;
   logic [7:0]  parallel_data;
   logic [3:0]  pops;
   int          n_fail = 0, checks = 0, cyc = 0, nbits = 0;
   adc_output_port #(.CONV_CYCLES(20)) dut (.ref_clk, .rst, .chip_select_n, .read_convert, .half_select,
      .output_format_select, .clock_source_select, .power_down_in, .chain_in, .serial_shift_clock_in,
      .serial_shift_clock_out, .serial_shift_clock_oe, .serial_result_out, .parallel_data, .parallel_oe,
      .busy_n, .sample_valid, .sample_ready, .sample_data);
   sample_source src (.ref_clk, .rst, .sample_ready, .sample_valid, .sample_data, .pops);
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // every scenario finishes in well under a thousand cycles; reaching 5000 means it is hung
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   // gather bits at each rise of the generated clock
   always @(negedge ref_clk) begin
      if (serial_shift_clock_out && !prev_clk) begin
         bword <= {bword[14:0], serial_result_out};
         nbits <= nbits + 1;
      end
      prev_clk <= serial_shift_clock_out;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // command held 5 cycles; via_cs lets chip select make the edge
   task automatic convert(input bit via_cs);
      @(negedge ref_clk);
      if (via_cs) read_convert = 1'b0;
      else chip_select_n = 1'b0;
      @(negedge ref_clk);
      chip_select_n = 1'b0;
      read_convert  = 1'b0;
      repeat (5) @(negedge ref_clk);
      chip_select_n = 1'b1;
      read_convert  = 1'b1;
   endtask
   // bounded by the cycle ceiling
   task automatic wait_done();
      while (busy_n !== 1'b1) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic par_read(input logic [15:0] exp);
      chip_select_n = 1'b0;
      half_select   = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({15'h0, parallel_oe}, 16'h0001);
      chk({8'h00, parallel_data}, {8'h00, exp[15:8]});
      half_select = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, parallel_data}, {8'h00, exp[7:0]});
      chip_select_n = 1'b1;
   endtask
   initial begin
      {rst, chip_select_n, read_convert, clock_source_select, output_format_select} = 5'h1F;
      {half_select, power_down_in, chain_in, serial_shift_clock_in, prev_clk} = 5'h00;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      convert(1'b0);
      wait_done();
      par_read(16'h9234);
      clock_source_select = 1'b0;
      output_format_select = 1'b0;
      chain_in = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk({15'h0, serial_shift_clock_oe}, 16'h0001);
      nbits = 0;
      convert(1'b1);
      chain_in = 1'b0;
      wait_done();
      chk(nbits[15:0], 16'h0010);
      chk(bword, 16'h9234);
      chk({15'h0, serial_result_out}, 16'h0001);
      output_format_select = 1'b1;
      nbits = 0;
      convert(1'b0);
      chain_in = 1'b1;
      wait_done();
      chk(bword, 16'hA5C3);
      chk({15'h0, serial_result_out}, 16'h0000);
      clock_source_select = 1'b0 + 1'b1;
      output_format_select = 1'b0;
      repeat (5) @(negedge ref_clk);
      chk({15'h0, serial_shift_clock_oe}, 16'h0000);
      convert(1'b0);
      convert(1'b1);
      wait_done();
      chk({12'h0, pops}, 16'h0004);
      par_read(16'h3C5A);
      power_down_in = 1'b1;
      repeat (4) @(negedge ref_clk);
      convert(1'b0);
      repeat (30) @(negedge ref_clk);
      chk({15'h0, busy_n}, 16'h0001);
      chk({12'h0, pops}, 16'h0004);
      power_down_in = 1'b0;
      chip_select_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         word = {word[14:0], serial_result_out};
         serial_shift_clock_in = 1'b1;
         repeat (4) @(negedge ref_clk);
         serial_shift_clock_in = 1'b0;
         repeat (4) @(negedge ref_clk);
      end
      chk(word, 16'h3C5A);
      chain_in = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({15'h0, serial_result_out}, 16'h0001);
      chain_in = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({15'h0, serial_result_out}, 16'h0000);
      stop_test();
   end
endmodule
